// [src/febe_pkg.sv]
// package for the far-end block error counter
package febe_pkg;

  localparam int unsigned FEBE_CNT_W = 16;
  localparam int unsigned FEBE_BYTE_W = 8;
  localparam int unsigned FEBE_ADDR_W = 12;

  // register indices; byte address is four times the index
  localparam logic [FEBE_ADDR_W-1:0] FEBE_IDX_HIGH   = 12'h907;
  localparam logic [FEBE_ADDR_W-1:0] FEBE_IDX_LOW    = 12'h908;
  localparam logic [FEBE_ADDR_W-1:0] FEBE_IDX_STATUS = 12'h910;
  localparam logic [FEBE_ADDR_W-1:0] FEBE_IDX_CLEAR  = 12'h911;
  localparam logic [FEBE_ADDR_W-1:0] FEBE_IDX_ENABLE = 12'h912;
  localparam logic [FEBE_ADDR_W-1:0] FEBE_IDX_CTRL   = 12'h913;

  localparam logic [7:0] FEBE_BYTE_RESET = 8'h00;
  localparam logic [15:0] FEBE_CNT_RESET = 16'h0000;

  // interrupt status bit positions
  localparam int unsigned FEBE_IRQ_EVENT = 0;
  localparam int unsigned FEBE_IRQ_WRAP  = 1;
  localparam int unsigned FEBE_IRQ_SYNC  = 2;
  localparam int unsigned FEBE_IRQ_W     = 3;
  localparam logic [2:0] FEBE_IRQ_RESET  = 3'h0;

  // control register bit: counting enable
  localparam int unsigned FEBE_CTRL_EN  = 0;
  localparam logic [0:0] FEBE_CTRL_RESET = 1'h1;

  // received line indications from the framer
  typedef struct packed {
    logic ebit_valid;
    logic ebit;
    logic fas_lost;
    logic crc_lost;
    logic cas_lost;
  } febe_line_t;

endpackage : febe_pkg

// [src/febe_counter.sv]
// far-end block error counter with wishbone register access
// Behaviour
// - the count is one 16-bit value shown as a high byte and a low byte register.
// - the count accumulates since the last read, clears when read, and resets to zero.
// - each received E-bit equal to zero adds one to the count.
// - counting stops while frame alignment or CRC-4 multiframe sync is lost.
// - counting continues while only CAS multiframe sync is lost.
// - a high byte read followed by a low byte read clears the whole 16-bit count.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module febe_counter
  import febe_pkg::*;
(
  input  wire logic        CLK,       // 20 MHz system clock
  input  wire logic        SYS_RST,   // async reset, active high
  input  wire logic        EBIT_VALID,// pin: E-bit strobe
  input  wire logic        EBIT,      // pin: received E-bit
  input  wire logic        FAS_LOST,  // pin: frame alignment lost
  input  wire logic        CRC_LOST,  // pin: CRC-4 multiframe lost
  input  wire logic        CAS_LOST,  // pin: CAS multiframe lost
  input  wire logic        CYC_I,     // wishbone cycle
  input  wire logic        STB_I,     // wishbone strobe
  input  wire logic        WE_I,      // wishbone write
  input  wire logic [3:0]  SEL_I,     // wishbone byte select
  input  wire logic [13:0] ADR_I,     // wishbone byte address
  input  wire logic [31:0] DAT_I,     // wishbone write data
  output logic      [31:0] DAT_O,     // wishbone read data
  output logic             ACK_O,     // wishbone acknowledge
  output logic             IRQ        // level interrupt
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  febe_line_t line_s1_reg;
  febe_line_t line_s2_reg;
  logic       ebit_v_d_reg;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      line_s1_reg  <= '0;
      line_s2_reg  <= '0;
      ebit_v_d_reg <= 1'b0;
    end else begin
      line_s1_reg  <= '{EBIT_VALID, EBIT, FAS_LOST, CRC_LOST, CAS_LOST};
      line_s2_reg  <= line_s1_reg;
      ebit_v_d_reg <= line_s2_reg.ebit_valid;
    end
  end

  wire logic ebit_strobe = line_s2_reg.ebit_valid & ~ebit_v_d_reg;
  wire logic sync_lost   = line_s2_reg.fas_lost | line_s2_reg.crc_lost;
  logic      ctrl_en_reg;
  // cas loss alone does not gate counting
  wire logic count_ok    = ctrl_en_reg & ~sync_lost;
  wire logic err_event   = ebit_strobe & ~line_s2_reg.ebit & count_ok;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic                   bus_req  = CYC_I & STB_I & ~ACK_O;
  wire logic [FEBE_ADDR_W-1:0] idx      = ADR_I[13:2];
  wire logic                   hit_high = idx == FEBE_IDX_HIGH;
  wire logic                   hit_low  = idx == FEBE_IDX_LOW;
  wire logic                   hit_stat = idx == FEBE_IDX_STATUS;
  wire logic                   hit_clr  = idx == FEBE_IDX_CLEAR;
  wire logic                   hit_en   = idx == FEBE_IDX_ENABLE;
  wire logic                   hit_ctrl = idx == FEBE_IDX_CTRL;
  wire logic                   rd_high  = bus_req & ~WE_I & hit_high;
  wire logic                   rd_low   = bus_req & ~WE_I & hit_low;
  wire logic                   wr_lane0 = bus_req & WE_I & SEL_I[0];

  //////////////////////////////////////////////////////////////////////////////
  // counter: live count, low snapshot and snapshot-valid flag
  logic [FEBE_CNT_W-1:0]  count_reg;
  logic [FEBE_CNT_W-1:0]  count_next;
  logic [FEBE_BYTE_W-1:0] low_snap_reg;
  logic                   snap_valid_reg;
  logic [FEBE_CNT_W-1:0]  inc_val;

  assign inc_val = err_event ? 16'h0001 : 16'h0000;

  // high read clears the count, keeping the low byte in the snapshot
  always_comb begin
    if (rd_high) begin
      count_next = inc_val;
    end else if (rd_low && !snap_valid_reg) begin
      count_next = {count_reg[15:8], 8'h00} + inc_val;
    end else begin
      count_next = count_reg + inc_val;
    end
  end

  wire logic wrap_event = err_event & (count_reg == 16'hFFFF);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      count_reg      <= FEBE_CNT_RESET;
      low_snap_reg   <= FEBE_BYTE_RESET;
      snap_valid_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      if (rd_high) begin
        low_snap_reg   <= count_reg[7:0];
        snap_valid_reg <= 1'b1;
      end else if (rd_low) begin
        low_snap_reg   <= FEBE_BYTE_RESET;
        snap_valid_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupts and control
  logic [FEBE_IRQ_W-1:0] irq_stat_reg;
  logic [FEBE_IRQ_W-1:0] irq_en_reg;
  logic                  sync_d_reg;
  wire logic [FEBE_IRQ_W-1:0] irq_set = {sync_lost & ~sync_d_reg, wrap_event, err_event};
  wire logic [FEBE_IRQ_W-1:0] irq_clr = (wr_lane0 & hit_clr) ? DAT_I[2:0] : 3'h0;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_stat_reg <= FEBE_IRQ_RESET;
      irq_en_reg   <= FEBE_IRQ_RESET;
      ctrl_en_reg  <= FEBE_CTRL_RESET[0];
      sync_d_reg   <= 1'b0;
    end else begin
      // set wins over clear
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      sync_d_reg   <= sync_lost;
      if (wr_lane0 && hit_en) begin
        irq_en_reg <= DAT_I[2:0];
      end
      if (wr_lane0 && hit_ctrl) begin
        ctrl_en_reg <= DAT_I[FEBE_CTRL_EN];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux and acknowledge
  wire logic [7:0] low_view = snap_valid_reg ? low_snap_reg : count_reg[7:0];
  logic [31:0]     rd_data;

  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_high) begin
      rd_data[7:0] = count_reg[15:8];
    end else if (hit_low) begin
      rd_data[7:0] = low_view;
    end else if (hit_stat) begin
      rd_data[2:0] = irq_stat_reg;
    end else if (hit_en) begin
      rd_data[2:0] = irq_en_reg;
    end else if (hit_ctrl) begin
      rd_data[0] = ctrl_en_reg;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
      IRQ   <= 1'b0;
    end else begin
      ACK_O <= bus_req;
      DAT_O <= bus_req && !WE_I ? rd_data : 32'h0000_0000;
      IRQ   <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_en_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  count_inc_a: assert property (err_event && !rd_high && !rd_low |=>
    count_reg == $past(count_reg) + 16'h0001) else $error("count did not step");
  sync_hold_a: assert property (sync_lost && !rd_high && !rd_low |=>
    count_reg == $past(count_reg)) else $error("count moved without sync");
  cas_count_a: assert property (ebit_strobe && !line_s2_reg.ebit && ctrl_en_reg
    && !sync_lost && !rd_high && !rd_low |=> count_reg != $past(count_reg))
    else $error("count stalled on cas loss");
  high_clear_a: assert property (rd_high |=> count_reg[15:8] == 8'h00)
    else $error("high read did not clear");
  snap_keep_a: assert property (rd_high |=> low_snap_reg == $past(count_reg[7:0]))
    else $error("low snapshot wrong");
  low_read_a: assert property (rd_low && snap_valid_reg |=> DAT_O[7:0] ==
    $past(low_snap_reg) ##1 !snap_valid_reg[*1]) else $error("low read mismatch");
  high_data_a: assert property (rd_high |=> DAT_O[7:0] == $past(count_reg[15:8]))
    else $error("high byte data wrong");
  reset_zero_a: assert property ($fell(SYS_RST) |-> count_reg == 16'h0000)
    else $error("count not zero after reset");
  ack_once_a: assert property (ACK_O |=> !ACK_O) else $error("ack held two cycles");

  //////////////////////////////////////////////////////////////////////////////
  // bus handshake and read data framing

  // every taken request is answered on the next edge
  ack_pulse_a: assert property (bus_req |=>
    ACK_O)
    else $error("request not acknowledged");

  // no acknowledge without a request one edge earlier
  ack_cause_a: assert property (ACK_O |->
    $past(bus_req))
    else $error("acknowledge without request");

  // read data stays zero outside the acknowledge cycle
  dat_idle_a: assert property (!ACK_O |->
    DAT_O == 32'h0000_0000)
    else $error("read data outside ack");

  // only the low byte lane carries register data
  dat_upper_a: assert property (ACK_O |->
    DAT_O[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");

  // a write returns no data
  write_quiet_a: assert property (bus_req && WE_I |=>
    DAT_O == 32'h0000_0000)
    else $error("write returned data");

  // byte lanes other than lane 0 write nothing
  sel_gate_a: assert property (bus_req && WE_I && !SEL_I[0] |=>
    irq_en_reg == $past(irq_en_reg) && ctrl_en_reg == $past(ctrl_en_reg))
    else $error("write without lane 0 took effect");

  //////////////////////////////////////////////////////////////////////////////
  // counting and the read sequence

  // a low read without a prior high read shows the live low byte
  low_live_a: assert property (rd_low && !snap_valid_reg |=>
    DAT_O[7:0] == $past(count_reg[7:0]))
    else $error("live low byte wrong");

  // that read clears the low byte only
  low_clear_a: assert property (rd_low && !snap_valid_reg && !err_event |=>
    count_reg[7:0] == 8'h00)
    else $error("low byte not cleared");

  // and leaves the high byte untouched
  high_keep_a: assert property (rd_low && !snap_valid_reg |=>
    count_reg[15:8] == $past(count_reg[15:8]))
    else $error("high byte changed on low read");

  // a high read arms the snapshot
  snap_set_a: assert property (rd_high |=>
    snap_valid_reg)
    else $error("snapshot not armed");

  // the low read ends the sequence
  snap_free_a: assert property (rd_low |=>
    !snap_valid_reg)
    else $error("snapshot not released");

  // an event in the high read cycle is kept
  high_event_a: assert property (rd_high && err_event |=>
    count_reg == 16'h0001)
    else $error("event lost on high read");

  // a quiet high read leaves an empty count
  high_quiet_a: assert property (rd_high && !err_event |=>
    count_reg == 16'h0000)
    else $error("count not cleared by high read");

  // nothing but events and reads moves the count
  no_event_a: assert property (!err_event && !rd_high && !rd_low |=>
    count_reg == $past(count_reg))
    else $error("count moved without event");

  // writes never touch the count
  count_ro_a: assert property (bus_req && WE_I && !err_event |=>
    count_reg == $past(count_reg))
    else $error("write changed count");

  // an E-bit of one is not an error
  ebit_one_a: assert property (ebit_strobe && line_s2_reg.ebit |->
    !err_event)
    else $error("counted a good e-bit");

  // frame alignment loss blocks counting
  fas_gate_a: assert property (line_s2_reg.fas_lost |->
    !err_event)
    else $error("counted during frame loss");

  // crc-4 multiframe loss blocks counting
  crc_gate_a: assert property (line_s2_reg.crc_lost |->
    !err_event)
    else $error("counted during crc loss");

  // software can hold the counter
  ctrl_gate_a: assert property (!ctrl_en_reg |->
    !err_event)
    else $error("counted while disabled");

  // one strobe edge gives one event
  strobe_once_a: assert property (ebit_strobe |=>
    !ebit_strobe)
    else $error("strobe edge repeated");

  //////////////////////////////////////////////////////////////////////////////
  // interrupt status, enable and control

  // an event sets its status bit
  stat_set_a: assert property (err_event |=>
    irq_stat_reg[FEBE_IRQ_EVENT])
    else $error("event status not set");

  // status stays until cleared
  stat_sticky_a: assert property (irq_stat_reg[FEBE_IRQ_EVENT] && !irq_clr[FEBE_IRQ_EVENT] |=>
    irq_stat_reg[FEBE_IRQ_EVENT])
    else $error("event status dropped");

  // a clear without a new event removes the bit
  clr_write_a: assert property (irq_clr[FEBE_IRQ_EVENT] && !err_event |=>
    !irq_stat_reg[FEBE_IRQ_EVENT])
    else $error("event status not cleared");

  // rollover from all ones flags a wrap and restarts at zero
  wrap_flag_a: assert property (wrap_event && !rd_high && !rd_low |=>
    irq_stat_reg[FEBE_IRQ_WRAP] && count_reg == 16'h0000)
    else $error("wrap not handled");

  // the onset of sync loss is flagged
  sync_flag_a: assert property (sync_lost && !sync_d_reg |=>
    irq_stat_reg[FEBE_IRQ_SYNC])
    else $error("sync loss not flagged");

  // the interrupt follows enabled status when enables are steady
  irq_level_a: assert property (!$past(wr_lane0 && hit_en) |->
    IRQ == |(irq_stat_reg & irq_en_reg))
    else $error("interrupt level wrong");

  // enable register takes the written bits
  en_write_a: assert property (wr_lane0 && hit_en |=>
    irq_en_reg == $past(DAT_I[2:0]))
    else $error("enable write lost");

  // control register takes the written enable
  ctrl_write_a: assert property (wr_lane0 && hit_ctrl |=>
    ctrl_en_reg == $past(DAT_I[FEBE_CTRL_EN]))
    else $error("control write lost");

  cover_event_c: cover property (err_event);
  cover_pair_c:  cover property (rd_high ##[1:20] rd_low);
  cover_irq_c:   cover property ($rose(IRQ));
  cover_cas_c:   cover property (line_s2_reg.cas_lost && err_event);
  cover_sync_c:  cover property (sync_lost && ebit_strobe && !line_s2_reg.ebit);

endmodule : febe_counter
`default_nettype wire

// [verif/febe_line_model.sv]
// framer side model: delivers e-bits and sync indications
`timescale 1ns/10ps
`default_nettype none
module febe_line_model
  import febe_pkg::*;
(
  input  wire logic       clk,  // bench clock
  output var  febe_line_t line  // e-bit strobe and sync state
);
  initial line = '0;
  // sync state settles before the strobe, strobe high two, low two plus gap
  task automatic send(input logic e, input logic [2:0] sy, input int gap);
    line.fas_lost <= sy[2];
    line.crc_lost <= sy[1];
    line.cas_lost <= sy[0];
    repeat (4) @(posedge clk);
    line.ebit_valid <= 1'b1;
    line.ebit       <= e;
    repeat (2) @(posedge clk);
    line.ebit_valid <= 1'b0;
    repeat (2 + gap) @(posedge clk);
    line.ebit <= ~e;  // bit time over: no stale value
  endtask : send
endmodule : febe_line_model
`default_nettype wire

// [verif/far_end_block_error_counter_tb_top.sv]
// testbench: e-bit counting, read sequence and interrupt
`timescale 1ns/10ps
`default_nettype none
module far_end_block_error_counter_tb_top
  import febe_pkg::*;
;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, irq;
  logic [3:0]  sel = 0;
  logic [13:0] adr = 0;
  logic [31:0] dat = 0, dat_o, r;
  febe_line_t  line;
  int miscompares = 0, num_checks = 0, cycles = 0, seed = 32'ha7425eda;
  int cnt = 0, snap = 0, en = 1;
  always #25 clk = ~clk;
  febe_counter i_dut (.CLK(clk), .SYS_RST(rst), .EBIT_VALID(line.ebit_valid),
    .EBIT(line.ebit), .FAS_LOST(line.fas_lost), .CRC_LOST(line.crc_lost),
    .CAS_LOST(line.cas_lost), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .SEL_I(sel),
    .ADR_I(adr), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .IRQ(irq));
  febe_line_model i_line (.clk(clk), .line(line));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask : chk
  task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= 4'hF;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    chk("ack", 32'h1, {31'h0, ack});
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic ev(input int gap);
    logic e;
    logic [2:0] sy;
    e  = ($random(seed) & 3) == 0;
    sy = {($random(seed) & 7) == 0, ($random(seed) & 7) == 0, ($random(seed) & 3) == 0};
    i_line.send(e, sy, gap);
    // zero e-bit counts unless frame or crc-4 sync is lost or counting is disabled
    if (!e && !sy[2] && !sy[1] && en != 0) cnt = (cnt + 1) & 16'hFFFF;
  endtask : ev
  task automatic read_pair(input int mid);
    wb(1'b0, FEBE_IDX_HIGH, 8'h00);
    chk("high byte", 32'((cnt >> 8) & 255), r);
    snap = cnt & 255;
    cnt  = 0;
    repeat (mid) ev(1);
    wb(1'b0, FEBE_IDX_LOW, 8'h00);
    chk("low byte", 32'(snap), r);
  endtask : read_pair
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b1, FEBE_IDX_LOW, 8'h5A);
    read_pair(0);
    wb(1'b0, 12'h0FF, 8'h00);
    chk("unmapped", 32'h0, r);
    for (int k = 0; k < 3; k++) begin
      en = (k != 1);
      wb(1'b1, FEBE_IDX_CTRL, 8'(en));
      wb(1'b0, FEBE_IDX_CTRL, 8'h00);
      chk("count enable", 32'(en), r);
      repeat (400 + ($random(seed) & 127)) ev($random(seed) & 3);
      read_pair(5);
    end
    read_pair(0);
    wb(1'b1, FEBE_IDX_ENABLE, 8'h01);
    wb(1'b0, FEBE_IDX_ENABLE, 8'h00);
    chk("irq enable", 32'h1, r);
    wb(1'b1, FEBE_IDX_CLEAR, 8'h07);
    repeat (2) @(posedge clk);
    chk("irq idle", 32'h0, {31'h0, irq});
    i_line.send(1'b0, 3'b001, 2);
    chk("irq set", 32'h1, {31'h0, irq});
    wb(1'b0, FEBE_IDX_STATUS, 8'h00);
    chk("status event", 32'h1, r & 32'h1);
    wb(1'b1, FEBE_IDX_CLEAR, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    cnt = 1;
    read_pair(0);
    tally_and_finish();
  end
endmodule : far_end_block_error_counter_tb_top
`default_nettype wire
